// ### design/flash_cmd_pkg.sv
// constants, register map and field layout of the flash driver command registers
//-----------------------------------------------------------------------------
//-----------------------------------------------------------------------------
package flash_cmd_pkg;

    // serial address of the device; value is arbitrary
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

    // register indices
    localparam logic [7:0] IDX_SHUTDOWN = 8'h00;
    localparam logic [7:0] IDX_CONFIG_A = 8'h01;
    localparam logic [7:0] IDX_CONFIG_B = 8'h02;
    localparam logic [7:0] IDX_FLASH1 = 8'h03;
    localparam logic [7:0] IDX_FLASH2 = 8'h04;
    localparam logic [7:0] IDX_TORCH = 8'h06;
    localparam logic [7:0] IDX_DELAY1 = 8'h07;
    localparam logic [7:0] IDX_DELAY2 = 8'h08;
    localparam logic [7:0] IDX_WIDTH1 = 8'h0A;
    localparam logic [7:0] IDX_WIDTH2 = 8'h0B;
    localparam logic [7:0] IDX_PHOTO_REF = 8'h0D;
    localparam logic [7:0] IDX_PHOTO_GAIN = 8'h0E;
    localparam logic [7:0] IDX_VOUT = 8'h0F;
    localparam logic [7:0] IDX_INDICATOR = 8'h10;
    localparam logic [7:0] IDX_THERM_LIMIT = 8'h11;
    localparam logic [7:0] IDX_THERM_BIAS = 8'h12;
    localparam logic [7:0] IDX_RECHARGE = 8'h13;
    localparam logic [7:0] IDX_TIMEOUT = 8'h14;
    localparam logic [7:0] IDX_STATUS = 8'h17;
    localparam int REG_COUNT = 21;
    localparam logic [7:0] REG_RESET = 8'h00;

    // field masks
    localparam logic [7:0] MASK_3BIT = 8'h07;
    localparam logic [7:0] MASK_5BIT = 8'h1F;
    localparam logic [7:0] MASK_6BIT = 8'h3F;
    localparam logic [7:0] MASK_7BIT = 8'h7F;
    localparam logic [7:0] MASK_8BIT = 8'hFF;

    // config A bit positions
    localparam int CFG_A_LED1_EN = 0;
    localparam int CFG_A_LED2_EN = 1;
    localparam int CFG_A_PHOTO_EN = 4;
    localparam int CFG_A_THERM_EN = 5;
    // config B bit positions
    localparam int CFG_B_INDICATOR = 0;
    localparam int CFG_B_PRECHARGE = 1;
    localparam int CFG_B_PUMP_ACT = 2;
    localparam int CFG_B_EXT_TRIG = 3;
    localparam int CFG_B_BUS_TRIG = 4;
    localparam int CFG_B_FLASH_MODE = 5;
    localparam int CFG_B_SOFT_RESET = 7;

    // torch current ceiling per LED in torch mode
    localparam int TORCH_LIMIT_MA = 100;
    localparam int TORCH_LSB_MA = 2;
    localparam logic [5:0] TORCH_LIMIT_CODE = 6'(TORCH_LIMIT_MA / TORCH_LSB_MA);

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_INDEX = 9'h008,
        ST_INDEX_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RDATA_ACK = 9'h100
    } serial_state_e;

    // writable bits of each register; unlisted indices hold nothing
    function automatic logic [7:0] regMask(input logic [7:0] idx);
        case (idx)
            IDX_CONFIG_A, IDX_CONFIG_B: regMask = MASK_8BIT;
            IDX_VOUT, IDX_RECHARGE: regMask = MASK_3BIT;
            IDX_THERM_LIMIT: regMask = MASK_5BIT;
            IDX_FLASH1, IDX_FLASH2, IDX_TORCH, IDX_INDICATOR, IDX_THERM_BIAS: regMask = MASK_6BIT;
            IDX_TIMEOUT: regMask = MASK_7BIT;
            IDX_DELAY1, IDX_DELAY2, IDX_WIDTH1, IDX_WIDTH2: regMask = MASK_8BIT;
            IDX_PHOTO_REF, IDX_PHOTO_GAIN: regMask = MASK_8BIT;
            default: regMask = 8'h00;
        endcase
    endfunction

endpackage

// ### design/serial_line_monitor.sv
// start, stop and clock edge detection on the serial bus lines
`timescale 1ns/100ps
module serial_line_monitor
    import flash_cmd_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // bus lines as seen on the pins
    input wire logic sclIn,
    input wire logic sdaIn,
    // one-cycle line events
    output logic startSeen,
    output logic stopSeen,
    output logic sclRise,
    output logic sclFall
);
    logic sclPrev_reg;
    logic sclPrev_next;
    logic sdaPrev_reg;
    logic sdaPrev_next;

    always_comb begin
        sclPrev_next = sclIn;
        sdaPrev_next = sdaIn;
        // data moving while the clock is high marks frame boundaries
        startSeen = sclPrev_reg & sclIn & sdaPrev_reg & ~sdaIn;
        stopSeen = sclPrev_reg & sclIn & ~sdaPrev_reg & sdaIn;
        sclRise = ~sclPrev_reg & sclIn;
        sclFall = sclPrev_reg & ~sclIn;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclPrev_reg <= sclPrev_next;
            sdaPrev_reg <= sdaPrev_next;
        end
    end
endmodule

// ### design/flash_launch_arbiter.sv
// chooses the flash launch source and applies the torch current ceiling
`timescale 1ns/100ps
module flash_launch_arbiter
    import flash_cmd_pkg::*;
(
    // mode and trigger controls
    input wire logic flashModeSelect,
    input wire logic busFlashTrigger,
    input wire logic externalTriggerEnable,
    input wire logic extTriggerIn,
    // programmed currents
    input wire logic [5:0] flashCurrent,
    input wire logic [5:0] torchCurrent,
    // decisions
    output logic fireRequest,
    output logic fromExternal,
    output logic [5:0] ledCurrent
);
    always_comb begin
        fromExternal = externalTriggerEnable;
        if (!flashModeSelect) begin
            fireRequest = 1'b0;
        end else if (externalTriggerEnable) begin
            // the pulse width on the pin is the flash width
            fireRequest = extTriggerIn;
        end else begin
            fireRequest = busFlashTrigger;
        end
        if (flashModeSelect) begin
            ledCurrent = flashCurrent;
        end else if (torchCurrent > TORCH_LIMIT_CODE) begin
            ledCurrent = TORCH_LIMIT_CODE;
        end else begin
            ledCurrent = torchCurrent;
        end
    end
endmodule

// ### design/flash_driver_command_registers.sv
// serial slave, register bank and shutdown control of the flash driver
`timescale 1ns/100ps
module flash_driver_command_registers
    import flash_cmd_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // serial bus, data line open drain
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // analog side inputs
    input wire logic extTriggerIn,
    input wire logic voutAtLeastTwoVolt,
    // power control
    output logic shutdownActive,
    output logic regulationEnable,
    output logic reservoirConnect,
    output logic reservoirBiasEnable,
    // LED control
    output logic [1:0] ledDriveOn,
    output logic [5:0] ledCurrent1,
    output logic [5:0] ledCurrent2,
    output logic flashFire,
    output logic indicatorEnable,
    // programmed settings
    output logic [2:0] voutCode,
    output logic [2:0] supercapRechargeCurrent,
    output logic [5:0] thermBiasCode,
    output logic [4:0] thermLimitCode,
    output logic [6:0] timeoutCode,
    output logic [5:0] indicatorLedCurrent,
    output logic [7:0] flashWidth1,
    output logic [7:0] flashWidth2,
    output logic [7:0] flashDelay1,
    output logic [7:0] flashDelay2,
    output logic [7:0] photoSenseRef,
    output logic [7:0] photoSenseGain,
    output logic thermistorProtection,
    output logic photoSenseEnable,
    output logic flashModeSelect,
    output logic busFlashTrigger,
    output logic externalTriggerEnable
);
    initial begin
        if (REG_COUNT > 32) begin
            $error("register bank exceeds five-bit index");
        end
    end

    //-------------------------------------------------------------------------
    // line events
    //-------------------------------------------------------------------------
    logic startSeen;
    logic stopSeen;
    logic sclRise;
    logic sclFall;

    serial_line_monitor lineMon (
        .ref_clk(ref_clk),
        .reset(reset),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .startSeen(startSeen),
        .stopSeen(stopSeen),
        .sclRise(sclRise),
        .sclFall(sclFall)
    );

    //-------------------------------------------------------------------------
    // register bank state
    //-------------------------------------------------------------------------
    logic [7:0] regFile_reg [REG_COUNT];
    logic [7:0] regFile_next [REG_COUNT];
    logic shutdown_reg;
    logic shutdown_next;
    logic commitWrite;

    // outputs derived from settings, registered below
    logic [1:0] ledDriveOn_reg;
    logic [1:0] ledDriveOn_next;
    logic [5:0] ledCurrent1_reg;
    logic [5:0] ledCurrent2_reg;
    logic flashFire_reg;
    logic flashFire_next;
    logic regulation_reg;
    logic regulation_next;
    logic reservoir_reg;
    logic reservoir_next;
    logic bias_reg;
    logic bias_next;
    logic indicator_reg;
    logic indicator_next;

    function automatic logic [7:0] readByte(input logic [7:0] idx);
        if (idx == IDX_STATUS) begin
            readByte = {5'h00, bias_reg, flashFire_reg, shutdown_reg};
        end else if (idx < 8'(REG_COUNT)) begin
            readByte = regFile_reg[idx[4:0]] & regMask(idx);
        end else begin
            readByte = 8'h00;
        end
    endfunction

    //-------------------------------------------------------------------------
    // serial slave
    //-------------------------------------------------------------------------
    serial_state_e state_reg;
    serial_state_e state_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [3:0] bitCnt_reg;
    logic [3:0] bitCnt_next;
    logic [7:0] index_reg;
    logic [7:0] index_next;
    logic readMode_reg;
    logic readMode_next;
    logic sdaOe_reg;
    logic sdaOe_next;
    logic [7:0] loadByte;

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        bitCnt_next = bitCnt_reg;
        index_next = index_reg;
        readMode_next = readMode_reg;
        sdaOe_next = sdaOe_reg;
        commitWrite = 1'b0;
        loadByte = readByte(index_reg);
        if (startSeen) begin
            // a repeated start abandons any byte in flight
            state_next = ST_ADDR;
            bitCnt_next = 4'h0;
            sdaOe_next = 1'b0;
        end else if (stopSeen) begin
            state_next = ST_IDLE;
            sdaOe_next = 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    sdaOe_next = 1'b0;
                end
                ST_ADDR, ST_INDEX, ST_WDATA: begin
                    if (sclRise) begin
                        shift_next = {shift_reg[6:0], sdaIn};
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end else if (sclFall && bitCnt_reg == 4'h8) begin
                        sdaOe_next = 1'b1;
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                readMode_next = shift_reg[0];
                                state_next = ST_ADDR_ACK;
                            end else begin
                                sdaOe_next = 1'b0;
                                state_next = ST_IDLE;
                            end
                        end else if (state_reg == ST_INDEX) begin
                            index_next = shift_reg;
                            state_next = ST_INDEX_ACK;
                        end else begin
                            state_next = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (sclFall) begin
                        bitCnt_next = 4'h0;
                        if (readMode_reg) begin
                            shift_next = loadByte;
                            sdaOe_next = ~loadByte[7];
                            state_next = ST_RDATA;
                        end else begin
                            sdaOe_next = 1'b0;
                            state_next = ST_INDEX;
                        end
                    end
                end
                ST_INDEX_ACK: begin
                    if (sclFall) begin
                        bitCnt_next = 4'h0;
                        sdaOe_next = 1'b0;
                        state_next = ST_WDATA;
                    end
                end
                ST_WDATA_ACK: begin
                    if (sclFall) begin
                        // the byte lands only once its acknowledge clock ends
                        commitWrite = 1'b1;
                        index_next = index_reg + 8'h01;
                        bitCnt_next = 4'h0;
                        sdaOe_next = 1'b0;
                        state_next = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (sclRise) begin
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_reg == 4'h8) begin
                            sdaOe_next = 1'b0;
                            state_next = ST_RDATA_ACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            sdaOe_next = ~shift_reg[6];
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (sclRise) begin
                        if (sdaIn) begin
                            state_next = ST_IDLE;
                        end else begin
                            index_next = index_reg + 8'h01;
                        end
                    end else if (sclFall) begin
                        bitCnt_next = 4'h0;
                        shift_next = loadByte;
                        sdaOe_next = ~loadByte[7];
                        state_next = ST_RDATA;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    sdaOe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bitCnt_reg <= 4'h0;
            index_reg <= 8'h00;
            readMode_reg <= 1'b0;
            sdaOe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            bitCnt_reg <= bitCnt_next;
            index_reg <= index_next;
            readMode_reg <= readMode_next;
            sdaOe_reg <= sdaOe_next;
        end
    end

    //-------------------------------------------------------------------------
    // register writes and shutdown
    //-------------------------------------------------------------------------
    always_comb begin
        regFile_next = regFile_reg;
        shutdown_next = shutdown_reg;
        if (commitWrite) begin
            if (index_reg == IDX_SHUTDOWN) begin
                // data value is ignored; settings are left untouched
                shutdown_next = 1'b1;
            end else if (index_reg == IDX_CONFIG_B && shift_reg[CFG_B_SOFT_RESET]) begin
                for (int i = 0; i < REG_COUNT; i++) begin
                    regFile_next[i] = REG_RESET;
                end
            end else if (index_reg < 8'(REG_COUNT)) begin
                // upper bits beyond each field are dropped
                regFile_next[index_reg[4:0]] = shift_reg & regMask(index_reg);
                if (index_reg == IDX_CONFIG_B
                        && (shift_reg[CFG_B_PUMP_ACT] || shift_reg[CFG_B_PRECHARGE])) begin
                    shutdown_next = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regFile_reg[i] <= REG_RESET;
            end
            shutdown_reg <= 1'b1;
        end else begin
            regFile_reg <= regFile_next;
            shutdown_reg <= shutdown_next;
        end
    end

    //-------------------------------------------------------------------------
    // flash launch and power control
    //-------------------------------------------------------------------------
    logic fireRequest;
    logic [5:0] arbCurrent1;
    logic [5:0] arbCurrent2;
    logic [7:0] cfgA;
    logic [7:0] cfgB;

    assign cfgA = regFile_reg[IDX_CONFIG_A[4:0]];
    assign cfgB = regFile_reg[IDX_CONFIG_B[4:0]];

    flash_launch_arbiter arb1 (
        .flashModeSelect(cfgB[CFG_B_FLASH_MODE]),
        .busFlashTrigger(cfgB[CFG_B_BUS_TRIG]),
        .externalTriggerEnable(cfgB[CFG_B_EXT_TRIG]),
        .extTriggerIn(extTriggerIn),
        .flashCurrent(regFile_reg[IDX_FLASH1[4:0]][5:0]),
        .torchCurrent(regFile_reg[IDX_TORCH[4:0]][5:0]),
        .fireRequest(fireRequest),
        .fromExternal(),
        .ledCurrent(arbCurrent1)
    );

    flash_launch_arbiter arb2 (
        .flashModeSelect(cfgB[CFG_B_FLASH_MODE]),
        .busFlashTrigger(cfgB[CFG_B_BUS_TRIG]),
        .externalTriggerEnable(cfgB[CFG_B_EXT_TRIG]),
        .extTriggerIn(extTriggerIn),
        .flashCurrent(regFile_reg[IDX_FLASH2[4:0]][5:0]),
        .torchCurrent(regFile_reg[IDX_TORCH[4:0]][5:0]),
        .fireRequest(),
        .fromExternal(),
        .ledCurrent(arbCurrent2)
    );

    always_comb begin
        flashFire_next = ~shutdown_reg & fireRequest;
        indicator_next = ~shutdown_reg & cfgB[CFG_B_INDICATOR];
        ledDriveOn_next[0] = ~shutdown_reg & cfgA[CFG_A_LED1_EN];
        ledDriveOn_next[1] = ~shutdown_reg & cfgA[CFG_A_LED2_EN];
        regulation_next = ~shutdown_reg & cfgB[CFG_B_PUMP_ACT];
        reservoir_next = ~shutdown_reg
            & (cfgB[CFG_B_PUMP_ACT] | cfgB[CFG_B_PRECHARGE]);
        // no discharge output exists: the capacitor decays through outside parts
        bias_next = shutdown_reg ? voutAtLeastTwoVolt : 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ledDriveOn_reg <= 2'h0;
            ledCurrent1_reg <= 6'h00;
            ledCurrent2_reg <= 6'h00;
            flashFire_reg <= 1'b0;
            regulation_reg <= 1'b0;
            reservoir_reg <= 1'b0;
            bias_reg <= 1'b0;
            indicator_reg <= 1'b0;
        end else begin
            ledDriveOn_reg <= ledDriveOn_next;
            ledCurrent1_reg <= arbCurrent1;
            ledCurrent2_reg <= arbCurrent2;
            flashFire_reg <= flashFire_next;
            regulation_reg <= regulation_next;
            reservoir_reg <= reservoir_next;
            bias_reg <= bias_next;
            indicator_reg <= indicator_next;
        end
    end

    //-------------------------------------------------------------------------
    // outputs
    //-------------------------------------------------------------------------
    // open drain: only ever pulls low
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_reg;
    assign shutdownActive = shutdown_reg;
    assign regulationEnable = regulation_reg;
    assign reservoirConnect = reservoir_reg;
    assign reservoirBiasEnable = bias_reg;
    assign ledDriveOn = ledDriveOn_reg;
    assign ledCurrent1 = ledCurrent1_reg;
    assign ledCurrent2 = ledCurrent2_reg;
    assign flashFire = flashFire_reg;
    assign indicatorEnable = indicator_reg;
    assign voutCode = regFile_reg[IDX_VOUT[4:0]][2:0];
    assign supercapRechargeCurrent = regFile_reg[IDX_RECHARGE[4:0]][2:0];
    assign thermBiasCode = regFile_reg[IDX_THERM_BIAS[4:0]][5:0];
    assign thermLimitCode = regFile_reg[IDX_THERM_LIMIT[4:0]][4:0];
    assign timeoutCode = regFile_reg[IDX_TIMEOUT[4:0]][6:0];
    assign indicatorLedCurrent = regFile_reg[IDX_INDICATOR[4:0]][5:0];
    assign flashWidth1 = regFile_reg[IDX_WIDTH1[4:0]];
    assign flashWidth2 = regFile_reg[IDX_WIDTH2[4:0]];
    assign flashDelay1 = regFile_reg[IDX_DELAY1[4:0]];
    assign flashDelay2 = regFile_reg[IDX_DELAY2[4:0]];
    assign photoSenseRef = regFile_reg[IDX_PHOTO_REF[4:0]];
    assign photoSenseGain = regFile_reg[IDX_PHOTO_GAIN[4:0]];
    assign thermistorProtection = cfgA[CFG_A_THERM_EN];
    assign photoSenseEnable = cfgA[CFG_A_PHOTO_EN];
    assign flashModeSelect = cfgB[CFG_B_FLASH_MODE];
    assign busFlashTrigger = cfgB[CFG_B_BUS_TRIG];
    assign externalTriggerEnable = cfgB[CFG_B_EXT_TRIG];
endmodule

// ### test/flash_cmd_chk.sv
// port assertions for the flash driver command registers
`timescale 1ns/100ps
module flash_cmd_chk (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic extTriggerIn,
    input wire logic voutAtLeastTwoVolt,
    input wire logic shutdownActive,
    input wire logic regulationEnable,
    input wire logic reservoirConnect,
    input wire logic reservoirBiasEnable,
    input wire logic [1:0] ledDriveOn,
    input wire logic [5:0] ledCurrent1,
    input wire logic flashFire,
    input wire logic flashModeSelect,
    input wire logic externalTriggerEnable,
    input wire logic [2:0] voutCode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // drive and power outputs follow the shutdown flag one edge later
    a_leds_off: assert property (
        shutdownActive && $past(shutdownActive) |-> ledDriveOn == 2'h0) else $error("led on");
    a_cap_released: assert property (
        shutdownActive && $past(shutdownActive) |-> !regulationEnable && !reservoirConnect)
        else $error("cap path");
    a_bias_tracks: assert property (!$past(reset) && shutdownActive && $past(shutdownActive)
        |-> reservoirBiasEnable == $past(voutAtLeastTwoVolt)) else $error("bias");
    a_settings_kept: assert property ($rose(shutdownActive) |-> $stable(voutCode))
        else $error("setting lost");
    a_torch_limit: assert property (!flashModeSelect [*3] |-> ledCurrent1 <= 6'h32)
        else $error("torch current");
    a_torch_no_fire: assert property (!flashModeSelect [*3] |-> !flashFire) else $error("fire");
    a_ext_wins: assert property (
        (flashModeSelect && externalTriggerEnable && !shutdownActive && !extTriggerIn) [*3]
        |-> !flashFire) else $error("bus fired");
    a_ext_fires: assert property (
        (flashModeSelect && externalTriggerEnable && !shutdownActive && extTriggerIn) [*3]
        |-> flashFire) else $error("ext no fire");
endmodule

bind flash_driver_command_registers flash_cmd_chk u_chk (.ref_clk, .reset, .extTriggerIn,
    .voutAtLeastTwoVolt, .shutdownActive, .regulationEnable, .reservoirConnect,
    .reservoirBiasEnable, .ledDriveOn, .ledCurrent1, .flashFire, .flashModeSelect,
    .externalTriggerEnable, .voutCode);

// ### test/flash_bus_host.sv
// serial bus host model that programs the flash driver registers
`timescale 1ns/100ps
module flash_bus_host (
    input wire logic ref_clk,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sdaLow
);
    initial {sclOut, sdaLow} = 2'h2;
    // 4-cycle phases keep clear of the 2-cycle minimum
    task automatic st(input logic c, input logic l);
        repeat (4) @(posedge ref_clk);
        {sclOut, sdaLow} <= {c, l};
    endtask
    // start, n bits msb first (a one releases the line), stop; data only moves with clock low
    task automatic frame(input logic [26:0] b, input int n, output logic [7:0] v);
        logic [26:0] r;
        st(1'b1, 1'b1);
        st(1'b0, 1'b1);
        for (int i = 26; i > 26 - n; i--) begin
            st(1'b0, ~b[i]);
            st(1'b1, ~b[i]);
            r[i] = sdaIn;
            st(1'b0, ~b[i]);
        end
        st(1'b0, 1'b1);
        st(1'b1, 1'b1);
        st(1'b1, 1'b0);
        v = r[17:10];
    endtask
endmodule

// ### test/flash_driver_command_registers_test.sv
// self-checking bench for the flash driver command registers
`timescale 1ns/100ps
module flash_driver_command_registers_test;
    import flash_cmd_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic extTriggerIn = 1'b0;
    logic voutOk = 1'b0;
    logic scl, sdaLow, sdaOe, shut, regOn, capOn, fire, therm, busTrig;
    logic [1:0] leds;
    logic [7:0] v;
    logic [7:0] expT [14];
    logic [15:0] seed = 16'hA3DA;
    logic [7:0] idxT [14] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0D, 8'h0F,
        8'h11, 8'h12, 8'h13, 8'h14, 8'h01};
    logic [7:0] mT [14] = '{8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07,
        8'h1F, 8'h3F, 8'h07, 8'h7F, 8'hFF};
    int fails = 0;
    int total_checks = 0;
    wire sda = ~(sdaOe | sdaLow);
    always #2 ref_clk = ~ref_clk;
    function automatic logic [15:0] nextRand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    always @(posedge ref_clk) begin
        seed <= nextRand(seed);
        voutOk <= seed[0];
    end
    flash_bus_host u_host (.ref_clk(ref_clk), .sdaIn(sda), .sclOut(scl), .sdaLow(sdaLow));
    flash_driver_command_registers u_dut (.ref_clk(ref_clk), .reset(reset), .sclIn(scl),
        .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .extTriggerIn(extTriggerIn),
        .voutAtLeastTwoVolt(voutOk), .shutdownActive(shut), .regulationEnable(regOn),
        .reservoirConnect(capOn), .reservoirBiasEnable(), .ledDriveOn(leds), .ledCurrent1(),
        .ledCurrent2(), .flashFire(fire), .indicatorEnable(), .voutCode(), .timeoutCode(),
        .supercapRechargeCurrent(), .thermBiasCode(), .thermLimitCode(), .flashWidth1(),
        .indicatorLedCurrent(), .flashWidth2(), .flashDelay1(), .flashDelay2(),
        .photoSenseRef(), .photoSenseGain(), .thermistorProtection(therm), .photoSenseEnable(),
        .flashModeSelect(), .busFlashTrigger(busTrig), .externalTriggerEnable());
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        fails += int'(s !== e);
        if (s !== e) $display("[ERR] %s expected %h seen %h", n, e, s);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // n counts the data bits sent plus their acknowledge; fewer than 9 aborts the byte
    task automatic wr(input logic [7:0] i, input logic [7:0] x, input int n);
        u_host.frame({DEV_ADDR_DEFAULT, 2'h1, i, 1'b1, x, 1'b1}, 18 + n, v);
    endtask
    task automatic rd(input logic [7:0] i);
        wr(i, 8'h00, 0);
        u_host.frame({DEV_ADDR_DEFAULT, 2'h3, 18'h3FE00}, 18, v);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        chk("shutdown", shut, 8'h01);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 14; i++) begin
                expT[i] = ((p == 0) ? 8'hFF : seed[7:0]) & mT[i];
                wr(idxT[i], expT[i], 9);
            end
            wr(8'h00, (p == 0) ? 8'h00 : seed[7:0], 9);
            chk("shutdown", shut, 8'h01);
            chk("power path", {leds, regOn, capOn}, 8'h00);
            wr(8'h0D, ~expT[7], 5);
            for (int i = 0; i < 14; i++) begin
                rd(idxT[i]);
                chk("readback", v, expT[i]);
            end
            wr(8'h02, 8'h04, 9);
            chk("awake", {leds, shut}, {5'h00, expT[13][1:0], 1'b0});
            $display("settings pass %0d done", p);
        end
        wr(8'h01, 8'h20, 9);
        chk("thermistor", therm, 8'h01);
        wr(8'h02, 8'h34, 9);
        chk("bus fire", {busTrig, fire}, 8'h03);
        wr(8'h02, 8'h3C, 9);
        chk("ext idle", fire, 8'h00);
        extTriggerIn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("ext fire", fire, 8'h01);
        wr(8'h02, 8'h1C, 9);
        chk("torch", fire, 8'h00);
        wr(8'h02, 8'h80, 9);
        rd(8'h0D);
        chk("clear", v, 8'h00);
        $display("trigger test done");
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        end_of_test();
    end
endmodule
